// ---- sff_frame_count.sv ----
// Package of shared constants and the per-direction frame position counter.
// Assumes step and start are single mclk pulses from the bit-clock edge logic.

`timescale 1ns/1ps
`default_nettype none

package sff_pkg;

  // Register word indices on the plain register port
  localparam logic [3:0] ADDR_RX_DATA_HIGH = 4'h0;
  localparam logic [3:0] ADDR_RX_DATA_LOW = 4'h1;
  localparam logic [3:0] ADDR_TX_DATA_HIGH = 4'h2;
  localparam logic [3:0] ADDR_TX_DATA_LOW = 4'h3;
  localparam logic [3:0] ADDR_RX_CFG1 = 4'h4;
  localparam logic [3:0] ADDR_RX_CFG2 = 4'h5;
  localparam logic [3:0] ADDR_TX_CFG1 = 4'h6;
  localparam logic [3:0] ADDR_TX_CFG2 = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  // Field layout of the configuration words
  localparam int COUNT_LSB = 0;
  localparam int COUNT_W = 7;
  localparam int SIZE_LSB = 8;
  localparam int SIZE_W = 3;
  localparam int DELAY_LSB = 12;
  localparam int DELAY_W = 2;
  localparam int DUAL_BIT = 15;
  localparam logic [15:0] CFG1_MASK = 16'h077F;
  localparam logic [15:0] CFG2_MASK = 16'hB77F;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // Status bit positions
  localparam int ST_RX_FULL = 0;
  localparam int ST_TX_FULL = 1;
  localparam int ST_RX_BUSY = 2;
  localparam int ST_TX_BUSY = 3;

  // Word size codes
  localparam logic [2:0] WS_8 = 3'h0;
  localparam logic [2:0] WS_12 = 3'h1;
  localparam logic [2:0] WS_16 = 3'h2;
  localparam logic [2:0] WS_20 = 3'h3;
  localparam logic [2:0] WS_24 = 3'h4;
  localparam logic [2:0] WS_32 = 3'h5;

  // First bit delay codes
  localparam logic [1:0] DLY_0 = 2'h0;
  localparam logic [1:0] DLY_1 = 2'h1;
  localparam logic [1:0] DLY_2 = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_SKIP, ST_WAIT, ST_DATA} sff_state_t;

  // Index of the last bit in a word; reserved codes fall back to 8 bits
  function automatic logic [4:0] sff_word_last(input logic [2:0] code);
    case (code)
      WS_8: sff_word_last = 5'h07;
      WS_12: sff_word_last = 5'h0B;
      WS_16: sff_word_last = 5'h0F;
      WS_20: sff_word_last = 5'h13;
      WS_24: sff_word_last = 5'h17;
      WS_32: sff_word_last = 5'h1F;
      default: sff_word_last = 5'h07;
    endcase
  endfunction

endpackage

module sff_frame_count (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Position events
  input wire logic start,
  input wire logic step,
  // Frame shape
  input wire logic dual,
  input wire logic [6:0] p1_count,
  input wire logic [6:0] p2_count,
  input wire logic [2:0] p1_size,
  input wire logic [2:0] p2_size,
  // Position of the bit moved now
  output logic [4:0] bit_cnt,
  output logic [4:0] word_last,
  output logic last_bit,
  output logic frame_end
);

  logic phase2_ff;
  logic [4:0] bit_ff;
  logic [6:0] word_ff;
  logic nxt_phase2;
  logic [4:0] nxt_bit;
  logic [6:0] nxt_word;
  wire base_phase2;
  wire last_word;
  wire [6:0] cur_count;
  wire [2:0] cur_size;

  // A start restarts the position even in mid-frame
  assign base_phase2 = start ? 1'b0 : phase2_ff;
  assign bit_cnt = start ? 5'h00 : bit_ff;
  // second size only in phase two
  assign cur_size = base_phase2 ? p2_size : p1_size;
  assign cur_count = base_phase2 ? p2_count : p1_count;
  assign word_last = sff_pkg::sff_word_last(cur_size);
  assign last_bit = (bit_cnt == word_last);
  assign last_word = ((start ? 7'h00 : word_ff) == cur_count);
  // single phase ends after phase one
  assign frame_end = step & last_bit & last_word & (base_phase2 | ~dual);

  // phase one words then phase two
  always_comb begin
    nxt_phase2 = base_phase2;
    nxt_bit = bit_cnt;
    nxt_word = start ? 7'h00 : word_ff;
    if (step) begin
      if (last_bit) begin
        nxt_bit = 5'h00;
        if (last_word) begin
          nxt_word = 7'h00;
          nxt_phase2 = ~base_phase2 & dual;
        end else begin
          nxt_word = nxt_word + 7'h01;
        end
      end else begin
        nxt_bit = bit_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phase2_ff <= 1'b0;
      bit_ff <= 5'h00;
      word_ff <= 7'h00;
    end else begin
      phase2_ff <= nxt_phase2;
      bit_ff <= nxt_bit;
      word_ff <= nxt_word;
    end
  end

endmodule

`default_nettype wire

// ---- sff_serial_frame.sv ----
// Frame format logic of a synchronous serial port, receive and transmit halves.
// Assumes bit clocks and frame syncs arrive asynchronously and run well below mclk.
//
// Chosen here: the strobed register port and the register offsets.

`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Word count field is words minus one
// - Phase bit selects single or dual phase
// - Dual frame: phase one then phase two
// - Size code gives 8 to 32 bits
// - Single phase ignores second size code
// - Short words use low register only
// - Frame starts at first sync-active cycle
// - Per-side first bit delay zero to two
// - Data starts on the sync cycle or up to two later
// - Zero delay receive samples at detection
// - Zero delay transmit drives preloaded bit
// - Two delay receive drops framing bit
// - Two delay transmit floats framing slot
// - Bits contiguous across words and phases
// - Separate receive and transmit settings
module sff_serial_frame (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Receive link
  input wire logic rx_bit_clock,
  input wire logic rx_frame_sync,
  input wire logic serial_data_in,
  // Transmit link
  input wire logic tx_bit_clock,
  input wire logic tx_frame_sync,
  output logic serial_data_out,
  output logic serial_data_out_en
);

  // Synchronisers, stage one read only by stage two
  logic rxc_s1_ff, rxc_s2_ff, rxc_s3_ff;
  logic rxf_s1_ff, rxf_s2_ff;
  logic rxd_s1_ff, rxd_s2_ff;
  logic txc_s1_ff, txc_s2_ff, txc_s3_ff;
  logic txf_s1_ff, txf_s2_ff;

  // Configuration
  logic [15:0] rx_cfg1_ff, rx_cfg2_ff, tx_cfg1_ff, tx_cfg2_ff;

  // Receive state
  sff_pkg::sff_state_t rx_state_ff, nxt_rx_state;
  logic rx_fs_prev_ff;
  logic [31:0] rx_shift_ff;
  logic [31:0] rx_buf_ff;
  logic rx_full_ff;

  // Transmit state
  sff_pkg::sff_state_t tx_state_ff, nxt_tx_state;
  logic tx_fs_prev_ff;
  logic [15:0] tx_hi_ff;
  logic [31:0] tx_buf_ff;
  logic [31:0] tx_word_ff;
  logic tx_full_ff;
  logic dout_ff, dout_en_ff;
  logic [15:0] rdata_ff;

  // Edge detection on the synchronised bit clocks
  wire rx_fall = ~rxc_s2_ff & rxc_s3_ff;
  wire tx_fall = ~txc_s2_ff & txc_s3_ff;
  wire tx_rise = txc_s2_ff & ~txc_s3_ff;

  // each side reads only its own fields
  wire rx_dual = rx_cfg2_ff[sff_pkg::DUAL_BIT];
  wire [1:0] rx_delay = rx_cfg2_ff[sff_pkg::DELAY_LSB +: sff_pkg::DELAY_W];
  wire [6:0] rx_p1_count = rx_cfg1_ff[sff_pkg::COUNT_LSB +: sff_pkg::COUNT_W];
  wire [6:0] rx_p2_count = rx_cfg2_ff[sff_pkg::COUNT_LSB +: sff_pkg::COUNT_W];
  wire [2:0] rx_p1_size = rx_cfg1_ff[sff_pkg::SIZE_LSB +: sff_pkg::SIZE_W];
  wire [2:0] rx_p2_size = rx_cfg2_ff[sff_pkg::SIZE_LSB +: sff_pkg::SIZE_W];
  wire tx_dual = tx_cfg2_ff[sff_pkg::DUAL_BIT];
  wire [1:0] tx_delay = tx_cfg2_ff[sff_pkg::DELAY_LSB +: sff_pkg::DELAY_W];
  wire [6:0] tx_p1_count = tx_cfg1_ff[sff_pkg::COUNT_LSB +: sff_pkg::COUNT_W];
  wire [6:0] tx_p2_count = tx_cfg2_ff[sff_pkg::COUNT_LSB +: sff_pkg::COUNT_W];
  wire [2:0] tx_p1_size = tx_cfg1_ff[sff_pkg::SIZE_LSB +: sff_pkg::SIZE_W];
  wire [2:0] tx_p2_size = tx_cfg2_ff[sff_pkg::SIZE_LSB +: sff_pkg::SIZE_W];

  // start is the inactive to active sync sample
  wire rx_start = rx_fall & rxf_s2_ff & ~rx_fs_prev_ff;
  wire tx_start = tx_fall & txf_s2_ff & ~tx_fs_prev_ff;

  // zero delay takes a bit on the detecting edge
  // otherwise bits begin on a later edge
  wire rx_step = rx_start ? (rx_delay == sff_pkg::DLY_0) :
    (rx_fall & ((rx_state_ff == sff_pkg::ST_WAIT) | (rx_state_ff == sff_pkg::ST_DATA)));
  // zero delay drives the first bit at detection
  wire tx_step = tx_start ? (tx_delay == sff_pkg::DLY_0) :
    (tx_rise & ((tx_state_ff == sff_pkg::ST_WAIT) | (tx_state_ff == sff_pkg::ST_DATA)));

  wire [4:0] rx_bit_cnt, tx_bit_cnt, tx_word_last;
  wire rx_last_bit, rx_frame_end, tx_frame_end;

  sff_frame_count u_rx_count (
    .mclk(mclk),
    .nrst(nrst),
    .start(rx_start),
    .step(rx_step),
    .dual(rx_dual),
    .p1_count(rx_p1_count),
    .p2_count(rx_p2_count),
    .p1_size(rx_p1_size),
    .p2_size(rx_p2_size),
    .bit_cnt(rx_bit_cnt),
    .word_last(),
    .last_bit(rx_last_bit),
    .frame_end(rx_frame_end)
  );

  sff_frame_count u_tx_count (
    .mclk(mclk),
    .nrst(nrst),
    .start(tx_start),
    .step(tx_step),
    .dual(tx_dual),
    .p1_count(tx_p1_count),
    .p2_count(tx_p2_count),
    .p1_size(tx_p1_size),
    .p2_size(tx_p2_size),
    .bit_cnt(tx_bit_cnt),
    .word_last(tx_word_last),
    .last_bit(),
    .frame_end(tx_frame_end)
  );

  // Receive word assembly, right-justified with zero fill
  wire [31:0] rx_assembled = (rx_bit_cnt == 5'h00) ? {31'h00000000, rxd_s2_ff} :
    {rx_shift_ff[30:0], rxd_s2_ff};
  wire rx_word_done = rx_step & rx_last_bit;

  // Transmit bit select, MSB first; first bit of a word comes from the buffer
  wire tx_word_first = (tx_bit_cnt == 5'h00);
  wire [4:0] tx_index = tx_word_last - tx_bit_cnt;
  wire tx_bit = tx_word_first ? tx_buf_ff[tx_word_last] : tx_word_ff[tx_index];
  wire tx_load = tx_step & tx_word_first;
  // idle output holds the first bit of the next frame
  wire tx_preload = tx_buf_ff[sff_pkg::sff_word_last(tx_p1_size)];

  // Register port decode
  wire rd_rx_low = reg_rd & (reg_addr == sff_pkg::ADDR_RX_DATA_LOW);
  wire wr_tx_high = reg_wr & (reg_addr == sff_pkg::ADDR_TX_DATA_HIGH);
  wire wr_tx_low = reg_wr & (reg_addr == sff_pkg::ADDR_TX_DATA_LOW);
  wire wr_rx_cfg1 = reg_wr & (reg_addr == sff_pkg::ADDR_RX_CFG1);
  wire wr_rx_cfg2 = reg_wr & (reg_addr == sff_pkg::ADDR_RX_CFG2);
  wire wr_tx_cfg1 = reg_wr & (reg_addr == sff_pkg::ADDR_TX_CFG1);
  wire wr_tx_cfg2 = reg_wr & (reg_addr == sff_pkg::ADDR_TX_CFG2);

  wire [15:0] status_word = {12'h000,
    tx_state_ff != sff_pkg::ST_IDLE,
    rx_state_ff != sff_pkg::ST_IDLE,
    tx_full_ff,
    rx_full_ff};

  logic [15:0] nxt_rdata;
  always_comb begin
    case (reg_addr)
      sff_pkg::ADDR_RX_DATA_HIGH: nxt_rdata = rx_buf_ff[31:16];
      sff_pkg::ADDR_RX_DATA_LOW: nxt_rdata = rx_buf_ff[15:0];
      sff_pkg::ADDR_TX_DATA_HIGH: nxt_rdata = tx_hi_ff;
      sff_pkg::ADDR_TX_DATA_LOW: nxt_rdata = tx_buf_ff[15:0];
      sff_pkg::ADDR_RX_CFG1: nxt_rdata = rx_cfg1_ff;
      sff_pkg::ADDR_RX_CFG2: nxt_rdata = rx_cfg2_ff;
      sff_pkg::ADDR_TX_CFG1: nxt_rdata = tx_cfg1_ff;
      sff_pkg::ADDR_TX_CFG2: nxt_rdata = tx_cfg2_ff;
      sff_pkg::ADDR_STATUS: nxt_rdata = status_word;
      default: nxt_rdata = 16'h0000;
    endcase
    if (!reg_rd) begin
      nxt_rdata = 16'h0000;
    end
  end

  // Delay state machines, shared shape for both sides
  // delay code picks the first state
  function automatic sff_pkg::sff_state_t start_state(input logic [1:0] dly);
    case (dly)
      sff_pkg::DLY_0: start_state = sff_pkg::ST_DATA;
      sff_pkg::DLY_1: start_state = sff_pkg::ST_WAIT;
      default: start_state = sff_pkg::ST_SKIP;
    endcase
  endfunction

  function automatic sff_pkg::sff_state_t walk_state(input sff_pkg::sff_state_t cur,
                                                     input logic edge_seen,
                                                     input logic ended);
    walk_state = cur;
    case (cur)
      sff_pkg::ST_IDLE: walk_state = sff_pkg::ST_IDLE;
      sff_pkg::ST_SKIP: begin
        if (edge_seen) begin
          walk_state = sff_pkg::ST_WAIT;
        end
      end
      sff_pkg::ST_WAIT: begin
        if (edge_seen) begin
          walk_state = sff_pkg::ST_DATA;
        end
      end
      sff_pkg::ST_DATA: walk_state = sff_pkg::ST_DATA;
      default: walk_state = sff_pkg::ST_IDLE;
    endcase
    if (ended) begin
      walk_state = sff_pkg::ST_IDLE;
    end
  endfunction

  // skip state lets the framing bit pass unused
  always_comb begin
    nxt_rx_state = walk_state(rx_state_ff, rx_fall, rx_frame_end);
    if (rx_start) begin
      nxt_rx_state = rx_frame_end ? sff_pkg::ST_IDLE : start_state(rx_delay);
    end
  end

  always_comb begin
    nxt_tx_state = walk_state(tx_state_ff, tx_rise, tx_frame_end);
    if (tx_start) begin
      nxt_tx_state = tx_frame_end ? sff_pkg::ST_IDLE : start_state(tx_delay);
    end
  end

  // Input synchronisers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {rxc_s1_ff, rxc_s2_ff, rxc_s3_ff} <= 3'h0;
      {rxf_s1_ff, rxf_s2_ff, rxd_s1_ff, rxd_s2_ff} <= 4'h0;
      {txc_s1_ff, txc_s2_ff, txc_s3_ff} <= 3'h0;
      {txf_s1_ff, txf_s2_ff} <= 2'h0;
    end else begin
      {rxc_s3_ff, rxc_s2_ff, rxc_s1_ff} <= {rxc_s2_ff, rxc_s1_ff, rx_bit_clock};
      {rxf_s2_ff, rxf_s1_ff} <= {rxf_s1_ff, rx_frame_sync};
      {rxd_s2_ff, rxd_s1_ff} <= {rxd_s1_ff, serial_data_in};
      {txc_s3_ff, txc_s2_ff, txc_s1_ff} <= {txc_s2_ff, txc_s1_ff, tx_bit_clock};
      {txf_s2_ff, txf_s1_ff} <= {txf_s1_ff, tx_frame_sync};
    end
  end

  // Configuration registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_cfg1_ff <= sff_pkg::CFG_RESET;
      rx_cfg2_ff <= sff_pkg::CFG_RESET;
      tx_cfg1_ff <= sff_pkg::CFG_RESET;
      tx_cfg2_ff <= sff_pkg::CFG_RESET;
    end else begin
      if (wr_rx_cfg1) rx_cfg1_ff <= reg_wdata & sff_pkg::CFG1_MASK;
      if (wr_rx_cfg2) rx_cfg2_ff <= reg_wdata & sff_pkg::CFG2_MASK;
      if (wr_tx_cfg1) tx_cfg1_ff <= reg_wdata & sff_pkg::CFG1_MASK;
      if (wr_tx_cfg2) tx_cfg2_ff <= reg_wdata & sff_pkg::CFG2_MASK;
    end
  end

  // Receive path
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_state_ff <= sff_pkg::ST_IDLE;
      rx_fs_prev_ff <= 1'b0;
      rx_shift_ff <= 32'h00000000;
      rx_buf_ff <= 32'h00000000;
      rx_full_ff <= 1'b0;
    end else begin
      rx_state_ff <= nxt_rx_state;
      if (rx_fall) rx_fs_prev_ff <= rxf_s2_ff;
      if (rx_step) rx_shift_ff <= rx_assembled;
      if (rx_word_done) rx_buf_ff <= rx_assembled;
      // low read completes the word; a new word wins
      rx_full_ff <= rx_word_done | (rx_full_ff & ~rd_rx_low);
    end
  end

  // Transmit path
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_state_ff <= sff_pkg::ST_IDLE;
      tx_fs_prev_ff <= 1'b0;
      tx_hi_ff <= 16'h0000;
      tx_buf_ff <= 32'h00000000;
      tx_word_ff <= 32'h00000000;
      tx_full_ff <= 1'b0;
    end else begin
      tx_state_ff <= nxt_tx_state;
      if (tx_fall) tx_fs_prev_ff <= txf_s2_ff;
      // high half waits for the low write
      if (wr_tx_high) tx_hi_ff <= reg_wdata;
      // low write alone commits a short word
      if (wr_tx_low) tx_buf_ff <= {tx_hi_ff, reg_wdata};
      if (tx_load) tx_word_ff <= tx_buf_ff;
      tx_full_ff <= wr_tx_low | (tx_full_ff & ~tx_load);
    end
  end

  // Serial output and enable; enable drops only on a rising bit-clock edge
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dout_ff <= 1'b0;
      dout_en_ff <= 1'b0;
    end else begin
      if (tx_step) begin
        dout_ff <= tx_bit;
        dout_en_ff <= 1'b1;
      end else if (tx_rise) begin
        // framing slot and idle stay floating
        if ((tx_state_ff == sff_pkg::ST_SKIP) | (tx_state_ff == sff_pkg::ST_IDLE)) begin
          dout_en_ff <= 1'b0;
        end
      end
      if (!dout_en_ff & (tx_state_ff == sff_pkg::ST_IDLE) & !tx_step) begin
        dout_ff <= tx_preload;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign serial_data_out = dout_ff;
  assign serial_data_out_en = dout_en_ff;

endmodule

`default_nettype wire

// ---- sff_serial_frame_chk.sv ----
// Checker for the frame block's register port and transmit pins.
// Assumes link inputs are slow against mclk and are sampled raw here.
`timescale 1ns/1ps
`default_nettype none
module sff_serial_frame_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Transmit link
  input wire logic tx_bit_clock,
  input wire logic tx_frame_sync,
  input wire logic serial_data_out,
  input wire logic serial_data_out_en
);
  logic tx_clk_ff;
  logic [7:0] quiet_ff;
  logic [7:0] age_ff;
  logic [7:0] nxt_quiet;
  logic [7:0] nxt_age;
  // Saturate so long idle spans never wrap
  assign nxt_quiet = (tx_bit_clock != tx_clk_ff) ? 8'h00 : quiet_ff + {7'h00, quiet_ff != 8'hFF};
  assign nxt_age = tx_frame_sync ? 8'h00 : age_ff + {7'h00, age_ff != 8'hFF};
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_clk_ff <= 1'h0;
      quiet_ff <= 8'h00;
      age_ff <= 8'hFF;
    end else begin
      tx_clk_ff <= tx_bit_clock;
      quiet_ff <= nxt_quiet;
      age_ff <= nxt_age;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence s_rewrite(logic [3:0] a);
    reg_wr && reg_addr == a ##1 !reg_wr && !reg_rd ##1 reg_rd && reg_addr == a;
  endsequence

  AST_RDATA_ONE_CYCLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  AST_UNMAPPED_ZERO: assert property (reg_rd && reg_addr > sff_pkg::ADDR_STATUS |=>
    reg_rdata == 16'h0000) else $error("unmapped read not zero");
  AST_STATUS_UPPER_ZERO: assert property (reg_rd && reg_addr == sff_pkg::ADDR_STATUS |=>
    reg_rdata[15:4] == 12'h000) else $error("status spare bits set");
  AST_TX_CFG1_READBACK: assert property (s_rewrite(sff_pkg::ADDR_TX_CFG1) |=>
    reg_rdata == ($past(reg_wdata, 3) & sff_pkg::CFG1_MASK)) else $error("cfg1 readback");
  AST_RX_CFG2_READBACK: assert property (s_rewrite(sff_pkg::ADDR_RX_CFG2) |=>
    reg_rdata == ($past(reg_wdata, 3) & sff_pkg::CFG2_MASK)) else $error("cfg2 readback");
  AST_EN_RISE_NEAR_EDGE: assert property ($rose(serial_data_out_en) |-> quiet_ff < 8'h08)
    else $error("enable rose away from a bit clock edge");
  AST_EN_FALL_NEAR_EDGE: assert property ($fell(serial_data_out_en) |-> quiet_ff < 8'h08)
    else $error("enable fell away from a bit clock edge");
  AST_EN_AFTER_SYNC: assert property ($rose(serial_data_out_en) |-> age_ff < 8'h20)
    else $error("enable rose without a recent frame sync");
  // Late in a bit slot the driven bit must have settled
  AST_TX_HOLD: assert property (serial_data_out_en && quiet_ff > 8'h03 |->
    $stable(serial_data_out)) else $error("data out moved between bit edges");
endmodule

bind sff_serial_frame sff_serial_frame_chk u_chk (
  .mclk(mclk),
  .nrst(nrst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .tx_bit_clock(tx_bit_clock),
  .tx_frame_sync(tx_frame_sync),
  .serial_data_out(serial_data_out),
  .serial_data_out_en(serial_data_out_en)
);
`default_nettype wire

// ---- sff_codec.sv ----
// Behavioural serial codec on the far side of the frame block.
// Assumes the bench fills rx_q, one bit per slot, before each frame.
`timescale 1ns/1ps
`default_nettype none
module sff_codec (
  // Toward the receiver
  output logic rx_bit_clock,
  output logic rx_frame_sync,
  output logic serial_data_in,
  // Toward the transmitter
  output logic tx_bit_clock,
  output logic tx_frame_sync,
  input wire logic serial_data_out,
  input wire logic serial_data_out_en
);
  bit rx_q[$];
  logic tx_d_q[$];
  logic tx_en_q[$];
  initial begin
    rx_bit_clock = 1'h0;
    tx_bit_clock = 1'h0;
    rx_frame_sync = 1'h0;
    tx_frame_sync = 1'h0;
    serial_data_in = 1'h0;
  end
  // Clocks stand still between frames; short high phase gives turn-on room
  task automatic frame(input int slots);
    tx_d_q.delete();
    tx_en_q.delete();
    #7.3;
    for (int k = -1; k < slots; k++) begin
      // one-slot sync after an idle slot
      rx_frame_sync = (k == 0);
      tx_frame_sync = (k == 0);
      serial_data_in = (k >= 0) ? rx_q[k] : ~serial_data_in;
      rx_bit_clock = 1'h1;
      tx_bit_clock = 1'h1;
      #30;
      rx_bit_clock = 1'h0;
      tx_bit_clock = 1'h0;
      #50;
      if (k >= 0) begin
        tx_d_q.push_back(serial_data_out);
        tx_en_q.push_back(serial_data_out_en);
      end
    end
    // Released line must not keep its last value
    serial_data_in = ~serial_data_in;
  endtask
endmodule
`default_nettype wire

// ---- tb_serial_frame_format.sv ----
// Self-checking bench for the frame block with a codec model.
// Assumes the bind in the checker file attaches the assertions.
`timescale 1ns/1ps
`default_nettype none
module tb_serial_frame_format;
  logic mclk, nrst, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic rx_bit_clock, rx_frame_sync, serial_data_in;
  logic tx_bit_clock, tx_frame_sync, serial_data_out, serial_data_out_en;
  int n_fail = 0;
  int samples_checked = 0;
  integer seed = 32'hEDBB0E48;
  int wbits[6] = '{8, 12, 16, 20, 24, 32};
  // Each row: dual, count1, size1, count2, size2, rx delay, tx delay
  // no reserved size codes
  int tbl[7][7] = '{'{0, 0, 0, 3, 5, 1, 1}, '{0, 0, 5, 0, 0, 0, 2}, '{0, 3, 0, 9, 1, 2, 0},
    '{1, 0, 2, 1, 3, 1, 1}, '{0, 1, 1, 0, 0, 0, 1}, '{1, 0, 4, 0, 0, 2, 2},
    '{0, 127, 0, 0, 0, 1, 1}};

  sff_serial_frame u_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_bit_clock(rx_bit_clock), .rx_frame_sync(rx_frame_sync),
    .serial_data_in(serial_data_in), .tx_bit_clock(tx_bit_clock),
    .tx_frame_sync(tx_frame_sync), .serial_data_out(serial_data_out),
    .serial_data_out_en(serial_data_out_en));
  sff_codec u_codec (.rx_bit_clock(rx_bit_clock), .rx_frame_sync(rx_frame_sync),
    .serial_data_in(serial_data_in), .tx_bit_clock(tx_bit_clock),
    .tx_frame_sync(tx_frame_sync), .serial_data_out(serial_data_out),
    .serial_data_out_en(serial_data_out_en));

  initial mclk = 1'h0;
  always #5 mclk = ~mclk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask

  task automatic run_test(input int t);
    int dual, c1, s1, c2, s2, dr, dt, nb, slots, p, b, k;
    logic [31:0] tv, rv;
    logic [15:0] c1w, c2w, v;
    logic en;
    int sz[$];
    logic [31:0] ew[$];
    logic txb[$];
    {dual, c1, s1, c2, s2, dr, dt} = {tbl[t][0], tbl[t][1], tbl[t][2], tbl[t][3],
      tbl[t][4], tbl[t][5], tbl[t][6]};
    for (k = 0; k <= c1; k++) sz.push_back(wbits[s1]);
    for (k = 0; dual == 1 && k <= c2; k++) sz.push_back(wbits[s2]);
    nb = 0;
    foreach (sz[w]) nb += sz[w];
    slots = ((dr > dt) ? dr : dt) + nb + 1;
    c1w = {5'h00, s1[2:0], 1'h0, c1[6:0]};
    c2w = {dual[0], 1'h0, dr[1:0], 1'h0, s2[2:0], 1'h0, c2[6:0]};
    wr(sff_pkg::ADDR_RX_CFG1, c1w);
    wr(sff_pkg::ADDR_RX_CFG2, c2w);
    rd(sff_pkg::ADDR_RX_CFG2, v);
    check("rx_cfg2", v, c2w);
    c2w[13:12] = dt[1:0];
    wr(sff_pkg::ADDR_TX_CFG2, c2w);
    wr(sff_pkg::ADDR_TX_CFG1, c1w);
    rd(sff_pkg::ADDR_TX_CFG1, v);
    check("tx_cfg1", v, c1w);
    tv = $random(seed);
    // high half first, only for wide words
    if (wbits[s1] > 16 || (dual == 1 && wbits[s2] > 16))
      wr(sff_pkg::ADDR_TX_DATA_HIGH, tv[31:16]);
    wr(sff_pkg::ADDR_TX_DATA_LOW, tv[15:0]);
    rd(sff_pkg::ADDR_STATUS, v);
    check("status_loaded", v, 16'h0002);
    u_codec.rx_q.delete();
    for (k = 0; k < slots; k++) u_codec.rx_q.push_back(1'($random(seed)));
    // model skips the delay slots, MSB first
    p = dr;
    foreach (sz[w]) begin
      rv = 32'h00000000;
      for (b = 0; b < sz[w]; b++) begin
        rv = {rv[30:0], u_codec.rx_q[p]};
        p++;
      end
      ew.push_back(rv);
      for (b = sz[w] - 1; b >= 0; b--) txb.push_back(tv[b]);
    end
    fork
      u_codec.frame(slots);
      foreach (ew[w]) begin
        k = 0;
        do begin
          rd(sff_pkg::ADDR_STATUS, v);
          k++;
        end while (v[sff_pkg::ST_RX_FULL] !== 1'h1 && k < 300);
        check("rx_ready", v[sff_pkg::ST_RX_FULL], 1'h1);
        if (sz[w] > 16) begin
          rd(sff_pkg::ADDR_RX_DATA_HIGH, v);
          check("rx_high", v, ew[w][31:16]);
        end
        rd(sff_pkg::ADDR_RX_DATA_LOW, v);
        check("rx_low", v, ew[w][15:0]);
      end
    join
    for (k = 0; k < slots; k++) begin
      b = k - dt;
      en = (b >= 0 && b < nb);
      check("tx_en", u_codec.tx_en_q[k], en);
      if (en) check("tx_bit", u_codec.tx_d_q[k], txb[b]);
    end
    // Both sides idle, all words taken
    rd(sff_pkg::ADDR_STATUS, v);
    check("status_idle", v, 16'h0000);
  endtask

  task automatic close_out();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Longest frame is about 8k cycles; ten times the whole plan is ample
  initial begin
    #1000000;
    n_fail++;
    close_out();
  end

  initial begin
    logic [15:0] v;
    nrst = 1'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    repeat (20) @(posedge mclk);
    nrst <= 1'h1;
    repeat (4) @(posedge mclk);
    for (int a = 4; a < 16; a++) begin
      if (a != 8) begin
        rd(4'(a), v);
        check("reset_or_unmapped", v, 16'h0000);
      end
    end
    wr(4'hC, 16'hA5A5);
    rd(4'hC, v);
    check("unmapped_write", v, 16'h0000);
    for (int t = 0; t < 7; t++) run_test(t);
    close_out();
  end
endmodule
`default_nettype wire
